// ---- rtl/sfb_flash_ops.sv ----
/*
 * Serial flash buffer operations and status read, device side.
 * Samples the chip select, serial clock and serial input pins on
 * the core clock, decodes commands, drives the status stream and
 * starts array operations. Assumes the serial clock is well below
 * a quarter of the core clock and the array logic shares core_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module sfb_flash_ops #(
  // Arbitrary value, not a real density code
  parameter logic [3:0] DENSITY_CODE = 4'h5
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 spi_cs_n,
  input  wire logic                 spi_sck,
  input  wire logic                 spi_si,
  output logic                      spi_so,
  output logic                      spi_so_oe,
  input  wire logic                 page_bin_cfg,
  input  wire logic                 protect_en,
  input  wire logic                 write_fault_flag,
  input  wire logic                 lockdown_allowed_flag,
  input  wire logic                 buffer_one_hold_flag,
  input  wire logic                 buffer_two_hold_flag,
  input  wire logic                 erase_hold_flag,
  output sfb_pkg::sfb_arr_req_t     arr_req,
  input  wire logic                 arr_done,
  input  wire logic                 arr_mismatch
);

  typedef struct packed {
    logic              cs_prev;
    logic              sck_prev;
    logic [5:0]        bit_cnt;
    logic [31:0]       sh;
    logic              stat_mode;
    logic [3:0]        stat_idx;
    logic [7:0]        stat_byte;
    logic              so;
    logic              so_oe;
    sfb_pkg::sfb_cmd_t cmd;
  } sfb_front_t;

  sfb_front_t          st;
  sfb_front_t          next_st;
  logic [2:0]          pins_s;
  logic                cs_s;
  logic                sck_s;
  logic                si_s;
  logic                busy;
  logic                comp;
  sfb_pkg::sfb_flags_t flags;
  logic                cs_fall;
  logic                cs_rise;
  logic                sck_rise;
  logic                sck_fall;

  sfb_sync #(
    .WIDTH (3),
    .INIT  (sfb_pkg::PIN_SYNC_INIT)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in ({spi_cs_n, spi_sck, spi_si}),
    .sync_out (pins_s)
  );

  assign cs_s  = pins_s[2];
  assign sck_s = pins_s[1];
  assign si_s  = pins_s[0];

  sfb_engine u_engine (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .cmd          (st.cmd),
    .arr_done     (arr_done),
    .arr_mismatch (arr_mismatch),
    .arr_req      (arr_req),
    .busy         (busy),
    .comp         (comp)
  );

  // Live status, sampled into the shifter at each byte start
  always_comb begin
    flags.rdy      = ~busy;
    flags.comp     = comp;
    flags.protect  = protect_en;
    flags.page_bin = page_bin_cfg;
    flags.fault    = write_fault_flag;
    flags.lockdown = lockdown_allowed_flag;
    flags.ps2      = buffer_two_hold_flag;
    flags.ps1      = buffer_one_hold_flag;
    flags.es       = erase_hold_flag;
  end

  // Serial clock edges only count while select is low
  assign cs_fall  = st.cs_prev & ~cs_s;
  assign cs_rise  = ~st.cs_prev & cs_s;
  assign sck_rise = ~st.sck_prev & sck_s & ~cs_s;
  assign sck_fall = st.sck_prev & ~sck_s & ~cs_s;

  always_comb begin
    logic [7:0] opc;
    logic [7:0] sbyte;
    logic       full;
    logic       data;
    opc   = st.sh[31:24];
    sbyte = '0;
    full  = (st.bit_cnt == sfb_pkg::CMD_BITS);
    data  = (st.bit_cnt >= sfb_pkg::RMW_MIN_BITS);
    next_st           = st;
    next_st.cs_prev   = cs_s;
    next_st.sck_prev  = sck_s;
    next_st.cmd.start = 1'b0;

    if (cs_fall) begin
      next_st.bit_cnt   = '0;
      next_st.stat_mode = 1'b0;
      next_st.stat_idx  = '0;
    end

    if (sck_rise) begin
      if (st.bit_cnt < sfb_pkg::CMD_BITS) begin
        next_st.sh = {st.sh[30:0], si_s};
      end
      if (st.bit_cnt != sfb_pkg::BIT_CNT_MAX) begin
        next_st.bit_cnt = st.bit_cnt + 6'h01;
      end
      if (st.bit_cnt == sfb_pkg::OPC_LAST_BIT
          && {st.sh[6:0], si_s} == sfb_pkg::OPC_STATUS) begin
        next_st.stat_mode = 1'b1;
      end
    end

    // Output changes on the falling edge, ready for the next rise
    if (sck_fall && st.stat_mode) begin
      if (st.stat_idx[2:0] == 3'h0) begin
        sbyte = sfb_pkg::status_byte(st.stat_idx[3], flags,
                                     DENSITY_CODE);
        next_st.so        = sbyte[7];
        next_st.stat_byte = {sbyte[6:0], 1'b0};
      end else begin
        next_st.so        = st.stat_byte[7];
        next_st.stat_byte = {st.stat_byte[6:0], 1'b0};
      end
      next_st.stat_idx = st.stat_idx + 4'h1;
      next_st.so_oe    = 1'b1;
    end

    if (cs_rise) begin
      next_st.so        = 1'b0;
      next_st.so_oe     = 1'b0;
      next_st.stat_mode = 1'b0;
      next_st.cmd.page  = sfb_pkg::page_of(st.sh[23:0],
                                           page_bin_cfg);
      // Commands arriving while busy are dropped; only status works
      if (!busy) begin
        case (opc)
          sfb_pkg::OPC_COPY_B1, sfb_pkg::OPC_COPY_B2: begin
            next_st.cmd.start   = full;
            next_st.cmd.op      = sfb_pkg::OP_COPY;
            next_st.cmd.buf_sel = opc[2];
          end
          sfb_pkg::OPC_CMP_B1, sfb_pkg::OPC_CMP_B2: begin
            next_st.cmd.start   = full;
            next_st.cmd.op      = sfb_pkg::OP_COMPARE;
            next_st.cmd.buf_sel = opc[0];
          end
          sfb_pkg::OPC_RFR_B1, sfb_pkg::OPC_RFR_B2: begin
            next_st.cmd.start   = full | data;
            next_st.cmd.op      = data ? sfb_pkg::OP_RMW
                                       : sfb_pkg::OP_REFRESH;
            next_st.cmd.buf_sel = opc[0];
          end
          default: begin
            next_st.cmd.start = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st         <= '0;
      st.cs_prev <= sfb_pkg::CS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign spi_so    = st.so;
  assign spi_so_oe = st.so_oe;

  copy_opcode_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    st.cmd.start && st.cmd.op == sfb_pkg::OP_COPY
    |-> (st.sh[31:24] == sfb_pkg::OPC_COPY_B1 && !st.cmd.buf_sel)
     || (st.sh[31:24] == sfb_pkg::OPC_COPY_B2 && st.cmd.buf_sel))
    else $error("Copy started by wrong opcode");

  std_page_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    st.cmd.start && !page_bin_cfg |-> st.cmd.page == st.sh[19:9])
    else $error("Standard page field misdecoded");

  bin_page_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    st.cmd.start && page_bin_cfg |-> st.cmd.page == st.sh[18:8])
    else $error("Binary page field misdecoded");

  start_on_rise_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    st.cmd.start |-> cs_s && $past(cs_rise) && !$past(busy))
    else $error("Operation started without select rise");

  compare_opcode_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    st.cmd.start && st.cmd.op == sfb_pkg::OP_COMPARE
    |-> st.sh[31:25] == sfb_pkg::OPC_CMP_B1[7:1]
        && st.bit_cnt == sfb_pkg::CMD_BITS)
    else $error("Compare started by wrong opcode");

  refresh_kind_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    st.cmd.start && (st.cmd.op == sfb_pkg::OP_RMW
                  || st.cmd.op == sfb_pkg::OP_REFRESH)
    |-> st.sh[31:25] == sfb_pkg::OPC_RFR_B1[7:1]
        && ((st.cmd.op == sfb_pkg::OP_RMW)
            == (st.bit_cnt >= sfb_pkg::RMW_MIN_BITS)))
    else $error("Refresh and modify mixed up");

  status_ready_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sck_fall && st.stat_mode && st.stat_idx[2:0] == 3'h0
    |=> spi_so == !$past(busy) && spi_so_oe)
    else $error("Ready bit wrong at byte start");

  status_wrap_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sck_fall && st.stat_mode && st.stat_idx == 4'hf
    |=> st.stat_idx == 4'h0 && st.stat_mode)
    else $error("Status pair did not wrap");

  release_so_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cs_rise |=> !spi_so_oe ##1 !spi_so_oe)
    else $error("Output not released at select rise");

  busy_drop_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cs_rise && busy |=> !st.cmd.start)
    else $error("Command taken while busy");

  status_drive_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sck_fall && st.stat_mode |=> spi_so_oe)
    else $error("Status bit not driven");

  idle_release_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cs_s && !cs_rise |-> !spi_so_oe)
    else $error("Output driven while deselected");

  status_cov: cover property (
    @(posedge core_clk) disable iff (!rst_n)
    sck_fall && st.stat_mode && st.stat_idx == 4'hf);

  compare_cov: cover property (
    @(posedge core_clk) disable iff (!rst_n)
    st.cmd.start && st.cmd.op == sfb_pkg::OP_COMPARE);

  rmw_cov: cover property (
    @(posedge core_clk) disable iff (!rst_n)
    st.cmd.start && st.cmd.op == sfb_pkg::OP_RMW);

endmodule
`default_nettype wire

// ---- rtl/sfb_pkg.sv ----
/*
 * Shared constants, types and helpers for the serial flash buffer
 * operation and status block. Assumes one core clock domain.
 */
package sfb_pkg;

  localparam logic [7:0] OPC_COPY_B1  = 8'h53;
  localparam logic [7:0] OPC_COPY_B2  = 8'h55;
  localparam logic [7:0] OPC_CMP_B1   = 8'h60;
  localparam logic [7:0] OPC_CMP_B2   = 8'h61;
  localparam logic [7:0] OPC_RFR_B1   = 8'h58;
  localparam logic [7:0] OPC_RFR_B2   = 8'h59;
  localparam logic [7:0] OPC_STATUS   = 8'hd7;

  localparam logic [5:0] OPC_LAST_BIT = 6'h07;
  localparam logic [5:0] CMD_BITS     = 6'h20;
  localparam logic [5:0] RMW_MIN_BITS = 6'h28;
  localparam logic [5:0] BIT_CNT_MAX  = 6'h3f;

  localparam int         PAGE_BITS    = 11;
  localparam int         STD_PAGE_LSB = 9;
  localparam int         BIN_PAGE_LSB = 8;

  localparam logic [2:0] PIN_SYNC_INIT = 3'h4;
  localparam logic       CS_IDLE       = 1'b1;
  localparam logic       COMP_RESET    = 1'b0;

  typedef enum logic [1:0] {
    OP_COPY,
    OP_COMPARE,
    OP_REFRESH,
    OP_RMW
  } sfb_op_t;

  typedef enum logic [1:0] {
    ARR_COPY,
    ARR_COMPARE,
    ARR_PROGRAM,
    ARR_RMW
  } sfb_arr_t;

  typedef enum logic [1:0] {
    EN_IDLE,
    EN_WAIT,
    EN_CMP,
    EN_REF
  } sfb_eng_state_t;

  typedef struct packed {
    logic                 start;
    sfb_op_t              op;
    logic                 buf_sel;
    logic [PAGE_BITS-1:0] page;
  } sfb_cmd_t;

  typedef struct packed {
    logic                 req;
    sfb_arr_t             kind;
    logic                 buf_sel;
    logic [PAGE_BITS-1:0] page;
  } sfb_arr_req_t;

  typedef struct packed {
    logic rdy;
    logic comp;
    logic protect;
    logic page_bin;
    logic fault;
    logic lockdown;
    logic ps2;
    logic ps1;
    logic es;
  } sfb_flags_t;

  function automatic logic [PAGE_BITS-1:0] page_of(
    input logic [23:0] addr,
    input logic        bin
  );
    page_of = bin ? addr[BIN_PAGE_LSB +: PAGE_BITS]
                  : addr[STD_PAGE_LSB +: PAGE_BITS];
  endfunction

  function automatic logic [7:0] status_byte(
    input logic       second,
    input sfb_flags_t f,
    input logic [3:0] density
  );
    if (second) begin
      status_byte = {f.rdy, 1'b0, f.fault, 1'b0, f.lockdown,
                     f.ps2, f.ps1, f.es};
    end else begin
      status_byte = {f.rdy, f.comp, density, f.protect, f.page_bin};
    end
  endfunction

endpackage

// ---- rtl/sfb_sync.sv ----
/*
 * Two flip-flop synchroniser for pins from outside the core clock.
 * Assumes each bit is an independent level.
 */
`timescale 1ns/10ps
`default_nettype none
module sfb_sync #(
  parameter int              WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sfb_sync_st_t;

  sfb_sync_st_t st;
  sfb_sync_st_t next_st;

  // First stage feeds only the second stage
  always_comb begin
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= {INIT, INIT};
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.s2;

endmodule
`default_nettype wire

// ---- rtl/sfb_engine.sv ----
/*
 * Array operation sequencer: copy, compare, refresh and
 * read-modify-write. Assumes the array answers each request
 * with a one-cycle done pulse on the core clock.
 */
`timescale 1ns/10ps
`default_nettype none
module sfb_engine (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire sfb_pkg::sfb_cmd_t     cmd,
  input  wire logic                  arr_done,
  input  wire logic                  arr_mismatch,
  output sfb_pkg::sfb_arr_req_t      arr_req,
  output logic                       busy,
  output logic                       comp
);

  typedef struct packed {
    sfb_pkg::sfb_eng_state_t state;
    sfb_pkg::sfb_arr_req_t   req;
    logic                    comp;
  } sfb_eng_st_t;

  sfb_eng_st_t st;
  sfb_eng_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.req.req = 1'b0;
    case (st.state)
      sfb_pkg::EN_IDLE: begin
        if (cmd.start) begin
          next_st.req.req     = 1'b1;
          next_st.req.buf_sel = cmd.buf_sel;
          next_st.req.page    = cmd.page;
          next_st.state       = sfb_pkg::EN_WAIT;
          case (cmd.op)
            sfb_pkg::OP_COPY: begin
              next_st.req.kind = sfb_pkg::ARR_COPY;
            end
            sfb_pkg::OP_COMPARE: begin
              next_st.req.kind = sfb_pkg::ARR_COMPARE;
              next_st.state    = sfb_pkg::EN_CMP;
            end
            sfb_pkg::OP_REFRESH: begin
              next_st.req.kind = sfb_pkg::ARR_COPY;
              next_st.state    = sfb_pkg::EN_REF;
            end
            default: begin
              next_st.req.kind = sfb_pkg::ARR_RMW;
            end
          endcase
        end
      end
      sfb_pkg::EN_REF: begin
        // Program back into the same page once the copy is done
        if (arr_done) begin
          next_st.req.req  = 1'b1;
          next_st.req.kind = sfb_pkg::ARR_PROGRAM;
          next_st.state    = sfb_pkg::EN_WAIT;
        end
      end
      sfb_pkg::EN_CMP: begin
        if (arr_done) begin
          next_st.comp  = arr_mismatch;
          next_st.state = sfb_pkg::EN_IDLE;
        end
      end
      sfb_pkg::EN_WAIT: begin
        if (arr_done) begin
          next_st.state = sfb_pkg::EN_IDLE;
        end
      end
      default: begin
        next_st.state = sfb_pkg::EN_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st      <= '0;
      st.comp <= sfb_pkg::COMP_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign arr_req = st.req;
  assign busy    = (st.state != sfb_pkg::EN_IDLE);
  assign comp    = st.comp;

  busy_after_start_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    cmd.start && !busy |=> busy && arr_req.req)
    else $error("Engine not busy after start");

  comp_result_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    st.state == sfb_pkg::EN_CMP && arr_done
    |=> comp == $past(arr_mismatch) && !busy)
    else $error("Compare result not stored");

  refresh_seq_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    st.state == sfb_pkg::EN_REF && arr_done
    |=> arr_req.req && arr_req.kind == sfb_pkg::ARR_PROGRAM
        && busy)
    else $error("Refresh did not program back");

  refresh_cov: cover property (
    @(posedge core_clk) disable iff (!rst_n)
    arr_req.req && arr_req.kind == sfb_pkg::ARR_PROGRAM);

endmodule
`default_nettype wire

// ---- testbench/sfb_host.sv ----
/*
 * Behavioural host serial master that drives the flash block's pins.
 * Assumes the caller waits for each frame to end before the next.
 */
`timescale 1ns/10ps
`default_nettype none
module sfb_host (
  output var logic spi_cs_n,
  output var logic spi_sck,
  output var logic spi_si,
  input  wire logic spi_so,
  input  wire logic spi_so_oe
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sck  = 1'b0;
    spi_si   = 1'b0;
  end

  // Returns the last n bits seen on the output line, newest at bit 0
  task automatic xfer(input logic [47:0] tx, input int n,
                      output logic [47:0] rx);
    rx = '0;
    spi_cs_n = 1'b0;
    #60;
    for (int i = 0; i < n; i++) begin
      spi_si = tx[47-i];
      #62.5 spi_sck = 1'b1;
      // Released line reads unknown so a missing enable is caught
      rx = {rx[46:0], spi_so_oe ? spi_so : 1'bx};
      #62.5 spi_sck = 1'b0;
    end
    #60 spi_cs_n = 1'b1;
    // Clock stands still between frames, data line wanders
    spi_si = ~spi_si;
    #200;
  endtask
endmodule
`default_nettype wire

// ---- testbench/test_sfb_flash_ops.sv ----
/*
 * Self-checking bench for the flash buffer operation block.
 * Assumes the host model drives the pins and the bench acts as array.
 */
`timescale 1ns/10ps
`default_nettype none
module test_sfb_flash_ops;
  // Arbitrary value, not a real density code
  localparam logic [3:0] DENS = 4'h5;
  logic                  core_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  page_bin_cfg = 1'b0;
  logic                  protect_en = 1'b0;
  logic                  arr_done = 1'b0;
  logic                  arr_mismatch = 1'b0;
  logic [4:0]            flg = '0;
  logic                  comp_exp = sfb_pkg::COMP_RESET;
  logic [31:0]           seed = 32'hbf48;
  logic [31:0]           r32;
  logic [47:0]           rx;
  wire logic             spi_cs_n, spi_sck, spi_si, spi_so, spi_so_oe;
  sfb_pkg::sfb_arr_req_t arr_req, last_req;
  int                    err_total = 0, n_checks = 0, req_cnt = 0;
  logic [7:0]            opcs [6] = '{8'h53, 8'h55, 8'h60, 8'h61,
                                     8'h58, 8'h59};

  always #5 core_clk = ~core_clk;

  sfb_host sfb_host_inst (.spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
    .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe));

  sfb_flash_ops #(.DENSITY_CODE(DENS)) sfb_flash_ops_inst (
    .core_clk(core_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n),
    .spi_sck(spi_sck), .spi_si(spi_si), .spi_so(spi_so),
    .spi_so_oe(spi_so_oe), .page_bin_cfg(page_bin_cfg),
    .protect_en(protect_en), .write_fault_flag(flg[4]),
    .lockdown_allowed_flag(flg[3]), .buffer_two_hold_flag(flg[2]),
    .buffer_one_hold_flag(flg[1]), .erase_hold_flag(flg[0]),
    .arr_req(arr_req), .arr_done(arr_done),
    .arr_mismatch(arr_mismatch));

  always @(posedge core_clk) begin
    if (arr_req.req === 1'b1) begin
      req_cnt <= req_cnt + 1;
      last_req <= arr_req;
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] exp_byte(input logic two,
                                          input logic rdy);
    if (two) begin
      return {rdy, 1'b0, flg[4], 1'b0, flg[3:0]};
    end
    return {rdy, comp_exp, DENS, protect_en, page_bin_cfg};
  endfunction

  task automatic conclude();
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [39:0] exp,
                     input logic [39:0] seen);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_req(input int target);
    for (int i = 0; i < 3000 && req_cnt < target; i++) begin
      @(posedge core_clk);
    end
    #1;
    if (req_cnt < target) begin
      err_total++;
      $display("BAD arr_req wait expected %0d seen %0d", target, req_cnt);
      conclude();
    end
  endtask

  // Reads k status bits after the opcode, then checks the release
  task automatic status(input logic rdy, input int k);
    logic [39:0] expv, mask;
    expv = {exp_byte(0, rdy), exp_byte(1, rdy), exp_byte(0, rdy),
            exp_byte(1, rdy), exp_byte(0, rdy)} >> (40 - k);
    mask = (40'h1 << k) - 40'h1;
    sfb_host_inst.xfer({8'hd7, 40'h0}, 8 + k, rx);
    chk("status stream", expv, rx[39:0] & mask);
    chk("so_oe after cs", 40'h0, 40'(spi_so_oe));
  endtask

  task automatic done_pulse(input logic mm);
    @(posedge core_clk);
    #1 arr_done = 1'b1;
    arr_mismatch = mm;
    @(posedge core_clk);
    #1 arr_done = 1'b0;
    arr_mismatch = ~mm;
  endtask

  task automatic run_op(input logic [7:0] opc, input logic [10:0] pg,
                        input int nbits);
    logic [23:0] a;
    logic [1:0]  kind;
    logic        bsel, mm, rfr;
    int          c0;
    r32 = rnd();
    mm = r32[13];
    a = page_bin_cfg ? {r32[4:0], pg, r32[12:5]}
                     : {r32[3:0], pg, r32[12:4]};
    rfr = (opc[7:4] == 4'h5) && opc[3];
    bsel = (opc[7:4] == 4'h5 && !opc[3]) ? opc[2] : opc[0];
    kind = opc[5] ? sfb_pkg::ARR_COMPARE :
           (rfr && nbits > 32) ? sfb_pkg::ARR_RMW : sfb_pkg::ARR_COPY;
    c0 = req_cnt;
    sfb_host_inst.xfer({opc, a, r32[31:24], 8'h00}, nbits, rx);
    wait_req(c0 + 1);
    chk("req kind", 40'(kind), 40'(last_req.kind));
    chk("req buf", 40'(bsel), 40'(last_req.buf_sel));
    chk("req page", 40'(pg), 40'(last_req.page));
    status(1'b0, 16);
    done_pulse(mm);
    if (rfr && nbits == 32) begin
      wait_req(c0 + 2);
      chk("rewrite kind", 40'(sfb_pkg::ARR_PROGRAM),
          40'(last_req.kind));
      chk("rewrite page", 40'(pg), 40'(last_req.page));
      status(1'b0, 8);
      done_pulse(~mm);
    end
    if (opc[5]) begin
      comp_exp = mm;
    end
    repeat (4) @(posedge core_clk);
    #1;
    status(1'b1, 16);
    chk("req count", 40'(c0 + ((rfr && nbits == 32) ? 2 : 1)),
        40'(req_cnt));
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    chk("so_oe idle", 40'h0, 40'(spi_so_oe));
    for (int r = 0; r < 4; r++) begin
      r32 = rnd();
      flg = r32[4:0];
      protect_en = r32[5];
      page_bin_cfg = r32[6];
      status(1'b1, 32);
    end
    // Every opcode in both page formats, corner pages at the ends
    for (int i = 0; i < 12; i++) begin
      r32 = rnd();
      page_bin_cfg = (i >= 6);
      run_op(opcs[i % 6], (i == 0) ? 11'h000 :
             (i == 11) ? 11'h7ff : r32[20:10], 32);
    end
    r32 = rnd();
    run_op(8'h59, r32[10:0], 40);
    // Bit counts one short and one over are refused
    for (int n = 31; n <= 33; n += 2) begin
      r32 = rnd();
      sfb_host_inst.xfer({8'h53, r32, 8'h00}, n, rx);
      repeat (50) @(posedge core_clk);
      #1;
      chk("refused count", 40'h11, 40'(req_cnt));
    end
    chk("refused total", 40'h11, 40'(req_cnt));
    status(1'b1, 3);
    conclude();
  end
endmodule
`default_nettype wire
